// ---- logic/scc_map.vh ----
`ifndef SCC_MAP_VH
`define SCC_MAP_VH
// ----------------------------------------
// widths and codes
// ----------------------------------------
`define SCC_NBITS 14
`define SCC_MSB_W 14'h2000
`define SCC_MID_BIN 14'h2000
`define SCC_MID_TWOS 14'h0000
// mode codes (one-hot)
`define SCC_MODE_NORMAL 3'h1
`define SCC_MODE_FAST 3'h2
`define SCC_MODE_SAVE 3'h4
// config word field positions
`define SCC_CFG_FAST 0
`define SCC_CFG_SAVE 1
`define SCC_CFG_BIP 2
`define SCC_CFG_SPAN 3
`define SCC_CFG_FMT 4
`define SCC_CFG_RST 5'h00
// ----------------------------------------
// timing, 125 MHz reference clock
// ----------------------------------------
`define SCC_CLK_MHZ 125
// conversion step period per mode, in clock cycles
`define SCC_STEP_FAST 4'h4
`define SCC_STEP_NORMAL 4'h5
`define SCC_STEP_SAVE 4'h6
// acquisition time, ns, and its cycle count
`define SCC_ACQ_NS 200
`define SCC_ACQ_CYC ((`SCC_ACQ_NS * `SCC_CLK_MHZ + 999) / 1000)
// fifo
`define SCC_FIFO_W 14
`define SCC_FIFO_D 8
`define SCC_FIFO_AW 3
`endif

// ---- logic/scc_fifo.v ----
// ----------------------------------------
// result fifo, flip-flop storage
// ----------------------------------------
module scc_fifo #(
   parameter W = 14,
   parameter D = 8,
   parameter AW = 3
)(
   input wire i_ref_clk, // clock
   input wire i_rstn, // async reset, low
   input wire i_valid, // write valid
   output wire o_ready, // not full
   input wire [W-1:0] i_data, // write data
   output wire o_valid, // not empty
   input wire i_ready, // read ready
   output wire [W-1:0] o_data // head word
);
   reg [W-1:0] mem_r [0:D-1];
   reg [AW-1:0] wp_r;
   reg [AW-1:0] rp_r;
   reg [AW:0] cnt_r;
   wire wr;
   wire rd;
   assign o_ready = (cnt_r != D);
   assign o_valid = (cnt_r != 0);
   assign o_data = mem_r[rp_r];
   assign wr = i_valid && o_ready;
   assign rd = o_valid && i_ready;
   // pointers and fill count
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         wp_r <= {AW{1'b0}};
         rp_r <= {AW{1'b0}};
         cnt_r <= {(AW+1){1'b0}};
      end
      else
      begin
         if (wr)
            wp_r <= wp_r + 1'b1;
         if (rd)
            rp_r <= rp_r + 1'b1;
         if (wr && !rd)
            cnt_r <= cnt_r + 1'b1;
         else if (rd && !wr)
            cnt_r <= cnt_r - 1'b1;
      end
   end
   // storage, no reset needed on data
   always @(posedge i_ref_clk)
   begin
      if (wr)
         mem_r[wp_r] <= i_data;
   end
endmodule // scc_fifo

// ---- logic/scc_core.v ----
`include "scc_map.vh"
module scc_core (
   input wire i_ref_clk, // 125 MHz clock
   input wire i_rstn, // async reset, low
   input wire i_conversion_start_n, // start pin, low starts
   input wire i_comp, // comparator decision, 1 keep bit
   input wire i_fast_select, // mode pin fast
   input wire i_save_select, // mode pin power save
   input wire i_bipolar_select, // range pin bipolar
   input wire i_double_span_select, // range pin double span
   input wire i_code_format_select, // 1 binary, 0 twos
   input wire i_sw_config, // 1 use config word
   input wire [4:0] i_cfg_word, // config word
   input wire i_cfg_write, // config word write strobe
   input wire i_serial_out, // 1 serial port, 0 parallel
   input wire i_rd_ready, // reader takes a result
   output reg o_busy, // conversion running
   output reg o_track, // sampling switches closed
   output reg [13:0] o_dac, // trial code to cdac
   output reg o_power_down, // analog circuits off
   output reg [2:0] o_mode, // active mode, one-hot
   output reg o_bipolar, // active bipolar range
   output reg o_double_span, // active double span
   output reg o_par_valid, // parallel result valid
   output reg [13:0] o_par_data, // parallel result
   output reg o_ser_valid, // serial result valid
   output reg [13:0] o_ser_data, // serial result
   output reg o_result_ready // fifo accepts results
);
   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   reg [1:0] cnv_s_r;
   reg cnv_d_r;
   reg [1:0] fast_s_r;
   reg [1:0] save_s_r;
   reg [1:0] bip_s_r;
   reg [1:0] span_s_r;
   reg [1:0] fmt_s_r;
   reg [1:0] comp_s_r;
   wire start_fall;
   // start sync resets high, its idle level, so no false edge after reset
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         cnv_s_r <= 2'h3;
         cnv_d_r <= 1'b1;
         fast_s_r <= 2'h0;
         save_s_r <= 2'h0;
         bip_s_r <= 2'h0;
         span_s_r <= 2'h0;
         fmt_s_r <= 2'h0;
         comp_s_r <= 2'h0;
      end
      else
      begin
         cnv_s_r <= {cnv_s_r[0], i_conversion_start_n};
         cnv_d_r <= cnv_s_r[1];
         fast_s_r <= {fast_s_r[0], i_fast_select};
         save_s_r <= {save_s_r[0], i_save_select};
         bip_s_r <= {bip_s_r[0], i_bipolar_select};
         span_s_r <= {span_s_r[0], i_double_span_select};
         fmt_s_r <= {fmt_s_r[0], i_code_format_select};
         comp_s_r <= {comp_s_r[0], i_comp};
      end
   end
   assign start_fall = cnv_d_r && !cnv_s_r[1];

   // ----------------------------------------
   // configuration source
   // ----------------------------------------
   reg [4:0] cfg_r;
   // config word comes from logic on this clock, so no synchroniser
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
         cfg_r <= `SCC_CFG_RST;
      else if (i_cfg_write)
         cfg_r <= i_cfg_word;
   end

   // mode decode, used for pins and config word alike
   function [2:0] mode_of;
      input f;
      input s;
      begin
         if (f && !s)
            mode_of = `SCC_MODE_FAST;
         else if (!f && s)
            mode_of = `SCC_MODE_SAVE;
         else
            mode_of = `SCC_MODE_NORMAL;
      end
   endfunction

   wire [2:0] mode_req;
   wire bip_req;
   wire span_req;
   wire fmt_req;
   // config word wins; mode pins ignored then
   assign mode_req = i_sw_config ? mode_of(cfg_r[`SCC_CFG_FAST], cfg_r[`SCC_CFG_SAVE])
                                 : mode_of(fast_s_r[1], save_s_r[1]);
   assign bip_req = i_sw_config ? cfg_r[`SCC_CFG_BIP] : bip_s_r[1];
   assign span_req = i_sw_config ? cfg_r[`SCC_CFG_SPAN] : span_s_r[1];
   assign fmt_req = i_sw_config ? cfg_r[`SCC_CFG_FMT] : fmt_s_r[1];

   // ----------------------------------------
   // conversion sequencer
   // ----------------------------------------
   localparam ST_ACQ = 4'h1;
   localparam ST_READY = 4'h2;
   localparam ST_CONV = 4'h4;
   localparam ST_DONE = 4'h8;
   reg [3:0] st_r;
   reg [7:0] acq_r;
   reg [3:0] step_r;
   reg [3:0] bit_r;
   reg [13:0] trial_w_r;
   reg fmt_r;
   reg [13:0] code_r;
   reg push_r;
   wire [3:0] step_len;
   wire fifo_ready;
   // step length sets throughput; power saving trades the longest step
   // for its lower rate, fast mode takes the shortest one
   wire step_save;
   wire step_fast;
   assign step_save = o_mode[2];
   assign step_fast = o_mode[1];
   assign step_len = step_save ? `SCC_STEP_SAVE :
                     (step_fast ? `SCC_STEP_FAST : `SCC_STEP_NORMAL);

   // sequencer; a start edge during conversion is ignored
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         st_r <= ST_ACQ;
         acq_r <= 8'h00;
         step_r <= 4'h0;
         bit_r <= 4'h0;
         trial_w_r <= 14'h0000;
         o_dac <= 14'h0000;
         o_busy <= 1'b0;
         o_track <= 1'b1;
         o_power_down <= 1'b0;
         o_mode <= `SCC_MODE_NORMAL;
         o_bipolar <= 1'b0;
         o_double_span <= 1'b0;
         fmt_r <= 1'b0;
         code_r <= 14'h0000;
         push_r <= 1'b0;
      end
      else
      begin
         push_r <= 1'b0;
         case (st_r)
            ST_ACQ:
            begin
               o_track <= 1'b1;
               o_power_down <= 1'b0;
               // new config latched during each acquisition
               o_mode <= mode_req;
               o_bipolar <= bip_req;
               o_double_span <= span_req;
               fmt_r <= fmt_req;
               if (acq_r == `SCC_ACQ_CYC - 1)
                  st_r <= ST_READY;
               else
                  acq_r <= acq_r + 8'h01;
            end
            ST_READY:
            begin
               // sample held as tracking stops on the start edge
               if (start_fall)
               begin
                  o_track <= 1'b0;
                  o_busy <= 1'b1;
                  o_dac <= `SCC_MSB_W;
                  trial_w_r <= `SCC_MSB_W;
                  bit_r <= 4'hd;
                  step_r <= 4'h0;
                  st_r <= ST_CONV;
               end
            end
            ST_CONV:
            begin
               // comparator arrives two flops late, so a step needs three cycles
               if (step_r == step_len - 4'h1)
               begin
                  step_r <= 4'h0;
                  // keep or clear trial bit, then try next lower
                  if (bit_r == 4'h0)
                  begin
                     code_r <= comp_s_r[1] ? o_dac : (o_dac & ~trial_w_r);
                     st_r <= ST_DONE;
                  end
                  else
                  begin
                     o_dac <= (comp_s_r[1] ? o_dac : (o_dac & ~trial_w_r))
                              | {1'b0, trial_w_r[13:1]};
                     trial_w_r <= {1'b0, trial_w_r[13:1]};
                     bit_r <= bit_r - 4'h1;
                  end
               end
               else
                  step_r <= step_r + 4'h1;
            end
            ST_DONE:
            begin
               // busy stays high until the fifo has room; the code is stored a cycle later
               if (fifo_ready)
               begin
                  push_r <= 1'b1;
                  o_busy <= 1'b0;
                  // analog off in save mode until acquisition powers it back up
                  o_power_down <= o_mode[2];
                  acq_r <= 8'h00;
                  st_r <= ST_ACQ;
               end
            end
            default:
               st_r <= ST_ACQ;
         endcase
      end
   end

   // ----------------------------------------
   // result buffer and output ports
   // ----------------------------------------
   wire [13:0] coded;
   wire f_valid;
   wire [13:0] f_data;
   wire take;
   // twos complement is binary with the msb flipped
   assign coded = fmt_r ? code_r : {~code_r[13], code_r[12:0]};

   // eight words absorb a slow reader before busy is held high
   scc_fifo #(
      .W(`SCC_FIFO_W),
      .D(`SCC_FIFO_D),
      .AW(`SCC_FIFO_AW)
   ) u_fifo (
      .i_ref_clk(i_ref_clk),
      .i_rstn(i_rstn),
      .i_valid(push_r),
      .o_ready(fifo_ready),
      .i_data(coded),
      .o_valid(f_valid),
      .i_ready(take),
      .o_data(f_data)
   );

   // output stage: head word held until reader takes it
   // a read and a new head in one cycle keep the port full, no bubble
   wire out_full;
   assign out_full = o_par_valid || o_ser_valid;
   assign take = f_valid && (!out_full || i_rd_ready);
   always @(posedge i_ref_clk or negedge i_rstn)
   begin
      if (!i_rstn)
      begin
         o_par_valid <= 1'b0;
         o_ser_valid <= 1'b0;
         o_par_data <= 14'h0000;
         o_ser_data <= 14'h0000;
         o_result_ready <= 1'b0;
      end
      else
      begin
         o_result_ready <= fifo_ready;
         if (take)
         begin
            o_par_valid <= !i_serial_out;
            o_ser_valid <= i_serial_out;
            o_par_data <= i_serial_out ? o_par_data : f_data;
            o_ser_data <= i_serial_out ? f_data : o_ser_data;
         end
         else if (i_rd_ready)
         begin
            o_par_valid <= 1'b0;
            o_ser_valid <= 1'b0;
         end
      end
   end
endmodule // scc_core

// ---- verif/scc_core_properties.sv ----
// ----------------------------------------
// port checker for the conversion core
// ----------------------------------------
module scc_core_chk (
   input wire i_ref_clk, // clock
   input wire i_rstn, // async reset, low
   input wire i_rd_ready, // reader takes word
   input wire o_busy, // conversion running
   input wire o_track, // sampling
   input wire [13:0] o_dac, // trial code
   input wire o_power_down, // analog off
   input wire [2:0] o_mode, // active mode
   input wire o_par_valid, // parallel valid
   input wire [13:0] o_par_data // parallel word
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (!i_rstn);
   // conversion start and its minimum body
   sequence s_start;
      $rose(o_busy);
   endsequence
   sequence s_hold;
      o_busy [*8];
   endsequence
   // bounds allow the slowest step length plus hand-off slack
   AST_TRIAL_MSB: assert property (s_start |-> o_dac == 14'h2000)
      else $error("first trial is not the msb weight");
   AST_BUSY_HOLD: assert property (s_start |-> s_hold)
      else $error("busy dropped inside the search");
   AST_BUSY_END: assert property (s_start |-> ##[55:90] !o_busy)
      else $error("busy did not fall after the search");
   AST_ACQ_FIRST: assert property (s_start |-> $past(o_track))
      else $error("conversion began without acquisition");
   AST_NO_TRACK: assert property (o_busy |-> !o_track)
      else $error("sampling while converting");
   AST_ONEHOT: assert property ($onehot(o_mode))
      else $error("mode not one-hot");
   AST_MODE_HOLD: assert property (o_busy && $past(o_busy) |-> $stable(o_mode))
      else $error("mode changed mid conversion");
   AST_PD_SAVE: assert property ($rose(o_power_down) |-> o_mode == 3'h4)
      else $error("power down outside save mode");
   AST_PD_BUSY: assert property (o_busy |-> !o_power_down)
      else $error("powered down while converting");
   AST_PAR_HOLD: assert property (o_par_valid && !i_rd_ready |=> o_par_valid && $stable(o_par_data))
      else $error("result word lost before read");
endmodule // scc_core_chk

bind scc_core scc_core_chk u_chk (.i_ref_clk, .i_rstn, .i_rd_ready, .o_busy, .o_track, .o_dac,
   .o_power_down, .o_mode, .o_par_valid, .o_par_data);

// ---- verif/scc_afe_model.sv ----
// ----------------------------------------
// analog front end stand-in
// ----------------------------------------
module scc_afe_model (
   input wire i_track, // sampling switches closed
   input wire [13:0] i_dac, // trial code
   input wire [13:0] i_level, // input level as ideal code
   output logic o_comp // 1 keeps trial bit
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [13:0] held_r = 14'h0000;
   // sample freezes as tracking stops
   always @(negedge i_track) held_r <= i_level;
   // ideal comparator, no offset or noise
   always_comb o_comp = (held_r >= i_dac);
endmodule // scc_afe_model

// ---- verif/tb.sv ----
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rstn = 0, st_n = 1, fast = 0, save = 0, bip = 0, span = 0;
   logic fmt = 1, swc = 0, wr = 0, ser = 0, rdy = 0, pdseen = 0;
   logic [4:0] cfg = 5'h00;
   logic [13:0] lvl = 14'h0000;
   wire comp, busy, track, pd, bo, so, par_v, ser_v, res_rdy;
   wire [13:0] dac, par_d, ser_d;
   wire [2:0] mode;
   int fail_count = 0, checked = 0, blen = 0;
   // ----------------------------------------
   // clock and instances
   // ----------------------------------------
   always #4 clk = ~clk;
   scc_core dut (.i_ref_clk(clk), .i_rstn(rstn), .i_conversion_start_n(st_n), .i_comp(comp),
      .i_fast_select(fast), .i_save_select(save), .i_bipolar_select(bip),
      .i_double_span_select(span), .i_code_format_select(fmt), .i_sw_config(swc),
      .i_cfg_word(cfg), .i_cfg_write(wr), .i_serial_out(ser), .i_rd_ready(rdy),
      .o_busy(busy), .o_track(track), .o_dac(dac), .o_power_down(pd), .o_mode(mode),
      .o_bipolar(bo), .o_double_span(so), .o_par_valid(par_v), .o_par_data(par_d),
      .o_ser_valid(ser_v), .o_ser_data(ser_d), .o_result_ready(res_rdy));
   scc_afe_model afe (.i_track(track), .i_dac(dac), .i_level(lvl), .o_comp(comp));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task results;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task chk(input logic [15:0] s, input logic [15:0] e);
      checked++;
      if (s !== e)
      begin
         fail_count++;
         $display("[FAIL] %0t seen %h expected %h", $time, s, e);
      end
   endtask
   function logic sig(int s);
      case (s)
         0: return busy;
         1: return par_v;
         default: return ser_v;
      endcase
   endfunction
   // sample at the falling edge so design updates have landed
   task wt(input int s, input logic v);
      int k;
      k = 0;
      while (sig(s) !== v)
      begin
         @(negedge clk);
         k++;
         if (k > 400)
         begin
            $display("[FAIL] %0t wait ran out", $time);
            fail_count++;
            results;
         end
      end
   endtask
   // start is spaced well past acquisition and sync delay
   task conv(input logic [13:0] v);
      @(posedge clk) lvl <= v;
      wt(0, 0);
      repeat (35) @(posedge clk);
      st_n <= 0;
      wt(0, 1);
      blen = 0;
      pdseen = 0;
      while (busy === 1'b1 && blen < 200)
      begin
         @(negedge clk);
         blen++;
         pdseen |= pd;
      end
      if (blen >= 200)
      begin
         $display("[FAIL] %0t busy never fell", $time);
         fail_count++;
         results;
      end
      repeat (3)
      begin
         @(negedge clk);
         pdseen |= pd;
      end
      @(posedge clk) st_n <= 1;
      @(negedge clk);
   endtask
   task rd(input logic s, input logic [13:0] e);
      @(negedge clk);
      wt(s ? 2 : 1, 1);
      chk(s ? ser_d : par_d, e);
      @(posedge clk) rdy <= 1;
      @(posedge clk) rdy <= 0;
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      chk(busy, 0);
      chk(track, 1);
      chk(mode, 3'h1);
      $display("test reset done");
   endtask
   // pin modes, ranges and format, search end codes
   task t_modes;
      logic [13:0] v[4];
      int st;
      v = '{14'h0000, 14'h3fff, 14'h2000, 14'h1fff};
      for (int k = 0; k < 4; k++)
      begin
         @(posedge clk);
         {save, fast} <= k[1:0];
         {span, bip} <= k[1:0];
         fmt <= k[1];
         st = (k == 1) ? 4 : (k == 2) ? 6 : 5;
         conv(v[k]);
         chk(mode, (k == 1) ? 3'h2 : (k == 2) ? 3'h4 : 3'h1);
         chk({so, bo}, k[1:0]);
         chk(pdseen, k == 2);
         chk(blen >= 14 * st - 2 && blen <= 14 * st + 4, 1);
         rd(0, k[1] ? v[k] : v[k] ^ 14'h2000);
      end
      $display("test modes done");
   endtask
   // config word overrides pins, serial port
   task t_sw;
      @(posedge clk);
      {swc, ser, wr, save, bip, span} <= 6'h3f;
      cfg <= 5'h01;
      @(posedge clk) wr <= 0;
      conv(14'h2abc);
      chk(mode, 3'h2);
      chk({so, bo}, 2'h0);
      rd(1, 14'h0abc);
      @(posedge clk);
      {cfg, wr} <= 6'h3d;
      @(posedge clk) wr <= 0;
      conv(14'h0123);
      chk(mode, 3'h4);
      rd(1, 14'h0123);
      @(posedge clk);
      {swc, ser, save, bip, span} <= 5'h00;
      $display("test config word done");
   endtask
   // reader stalls until the buffer refuses, then drains in order
   task t_fifo;
      int n;
      n = 0;
      while (res_rdy === 1'b1 && n < 12)
      begin
         conv(14'h0100 + 14'(n));
         repeat (4) @(negedge clk);
         n++;
      end
      chk(n >= 8 && n <= 9, 1);
      for (int i = 0; i < n; i++)
         rd(0, 14'h0100 + 14'(i));
      repeat (4) @(negedge clk);
      chk(par_v, 0);
      chk(res_rdy, 1);
      $display("test buffer done");
   endtask
   // main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      @(negedge clk);
      t_reset;
      t_modes;
      t_sw;
      t_fifo;
      results;
   end
endmodule // tb
